/* File: rtl/pirq_pkg.sv */
package pirq_pkg;
  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_FLAGS_ONE   = 8'h0c;
  localparam logic [7:0] OFS_FLAGS_TWO   = 8'h0d;
  localparam logic [7:0] OFS_ENABLES_ONE = 8'h8c;
  localparam logic [7:0] OFS_ENABLES_TWO = 8'h8d;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h8e;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h90;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h91;

  // field positions, flags one and enables one
  localparam int BIT_PARALLEL   = 7;
  localparam int BIT_CONVERSION = 6;
  localparam int BIT_RECEIVE    = 5;
  localparam int BIT_TRANSMIT   = 4;
  localparam int BIT_SERIAL     = 3;
  localparam int BIT_CCP_ONE    = 2;
  localparam int BIT_PERIOD     = 1;
  localparam int BIT_OVERFLOW   = 0;
  // flags two, enables two
  localparam int BIT_CCP_TWO    = 0;
  // reset cause
  localparam int BIT_POWERON    = 1;
  localparam int BIT_BROWNOUT   = 0;
  // event status: usart and second unit
  localparam int BIT_EV_USART   = 5;
  localparam int BIT_EV_CCP_TWO = 4;

  // stored (software writable) bits of flags one
  localparam logic [7:0] MASK_FLAGS_ONE = 8'hcf;

  // reset values
  localparam logic [7:0] RST_FLAGS    = 8'h00;
  localparam logic [7:0] RST_ENABLES  = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic       RST_POWERON  = 1'b0;
  localparam logic       RST_BROWNOUT = 1'b0;

  // peripheral condition pulses
  typedef struct packed {
    logic parallel_port;
    logic conversion_done;
    logic serial_port;
    logic capture_compare_one;
    logic period_match;
    logic timer_overflow;
    logic capture_compare_two;
  } pirq_event_t;

  // capture/compare units in pwm mode
  typedef struct packed {
    logic unit_one_pwm;
    logic unit_two_pwm;
  } pirq_ccp_mode_t;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } pirq_bus_req_t;
endpackage

/* File: rtl/pirq_reset_sync.sv */
`timescale 1ns/1ps
module pirq_reset_sync (
  // clock and raw reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // released reset
  output logic      rst_n_o
);
  logic stage_one;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage_one <= 1'b0;
      rst_n_o   <= 1'b0;
    end else begin
      stage_one <= 1'b1;
      rst_n_o   <= stage_one;
    end
  end
endmodule

/* File: rtl/pirq_flags.sv */
`timescale 1ns/1ps
module pirq_flags
  import pirq_pkg::*;
#(
  parameter bit HAS_PARALLEL_PORT = 1'b1,
  parameter bit HAS_CONVERTER     = 1'b1
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // register bus
  input  wire pirq_bus_req_t bus_req_i,
  output logic [DATA_W-1:0] rd_data_o,
  // peripheral conditions
  input  wire pirq_event_t    event_i,
  input  wire pirq_ccp_mode_t ccp_mode_i,
  input  wire logic        receive_full_i,
  input  wire logic        transmit_empty_i,
  // reset cause
  input  wire logic        brownout_event_i,
  input  wire logic        brownout_detect_enable_i,
  // core interface
  input  wire logic        peripheral_irq_enable_i,
  output logic             periph_irq_o,
  output logic             irq_o
);
  logic              rst_n;
  logic [7:0]        flags_one;
  logic [7:0]        enables_one;
  logic              capture_compare_two_flag;
  logic              capture_compare_two_enable;
  logic              poweron_status;
  logic              brownout_status;
  logic [7:0]        irq_status;
  logic [7:0]        irq_mask;
  logic              receive_q;
  logic              transmit_q;
  logic [7:0]        impl_mask;
  logic [7:0]        set_one;
  logic [7:0]        next_flags_one;
  logic [7:0]        flags_one_view;
  logic              next_ccp_two;
  logic [7:0]        status_set;
  logic [7:0]        next_rd_data;
  logic              wr_flags_one;
  logic              wr_flags_two;
  logic              wr_enables_one;
  logic              wr_enables_two;
  logic              wr_reset_cause;
  logic              wr_irq_mask;
  logic              rd_irq_status;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    return a == ofs;
  endfunction

  pirq_reset_sync u_reset_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .rst_n_o   (rst_n)
  );

  // write and read decode
  assign wr_flags_one   = bus_req_i.wr & hit(bus_req_i.addr, OFS_FLAGS_ONE);
  assign wr_flags_two   = bus_req_i.wr & hit(bus_req_i.addr, OFS_FLAGS_TWO);
  assign wr_enables_one = bus_req_i.wr & hit(bus_req_i.addr, OFS_ENABLES_ONE);
  assign wr_enables_two = bus_req_i.wr & hit(bus_req_i.addr, OFS_ENABLES_TWO);
  assign wr_reset_cause = bus_req_i.wr & hit(bus_req_i.addr, OFS_RESET_CAUSE);
  assign wr_irq_mask    = bus_req_i.wr & hit(bus_req_i.addr, OFS_IRQ_MASK);
  assign rd_irq_status  = bus_req_i.rd & hit(bus_req_i.addr, OFS_IRQ_STATUS);

  // absent peripherals leave reserved bits
  always_comb begin
    impl_mask = MASK_FLAGS_ONE;
    impl_mask[BIT_PARALLEL]   = HAS_PARALLEL_PORT;
    impl_mask[BIT_CONVERSION] = HAS_CONVERTER;
  end

  // condition pulses, enables not consulted
  always_comb begin
    set_one = 8'h00;
    set_one[BIT_PARALLEL]   = event_i.parallel_port;
    set_one[BIT_CONVERSION] = event_i.conversion_done;
    set_one[BIT_SERIAL]     = event_i.serial_port;
    set_one[BIT_CCP_ONE]    = event_i.capture_compare_one
                            & ~ccp_mode_i.unit_one_pwm;
    set_one[BIT_PERIOD]     = event_i.period_match;
    set_one[BIT_OVERFLOW]   = event_i.timer_overflow;
  end

  // set wins over a software clear
  always_comb begin
    next_flags_one = flags_one;
    if (wr_flags_one) begin
      next_flags_one = bus_req_i.wdata;
    end
    next_flags_one = (next_flags_one | set_one) & impl_mask;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags_one <= RST_FLAGS;
    end else begin
      flags_one <= next_flags_one;
    end
  end

  // usart bits are live levels, not stored
  always_comb begin
    flags_one_view = flags_one;
    flags_one_view[BIT_RECEIVE]  = receive_full_i;
    flags_one_view[BIT_TRANSMIT] = transmit_empty_i;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      enables_one <= RST_ENABLES;
    end else if (wr_enables_one) begin
      enables_one <= bus_req_i.wdata & (impl_mask | 8'h30);
    end
  end

  // second capture/compare unit
  always_comb begin
    next_ccp_two = capture_compare_two_flag;
    if (wr_flags_two) begin
      next_ccp_two = bus_req_i.wdata[BIT_CCP_TWO];
    end
    next_ccp_two = next_ccp_two
                 | (event_i.capture_compare_two
                    & ~ccp_mode_i.unit_two_pwm);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      capture_compare_two_flag <= RST_FLAGS[BIT_CCP_TWO];
    end else begin
      capture_compare_two_flag <= next_ccp_two;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      capture_compare_two_enable <= RST_ENABLES[BIT_CCP_TWO];
    end else if (wr_enables_two) begin
      capture_compare_two_enable <=
        bus_req_i.wdata[BIT_CCP_TWO];
    end
  end

  // power-on status: reset drives it low
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      poweron_status <= RST_POWERON;
    end else if (wr_reset_cause) begin
      poweron_status <= bus_req_i.wdata[BIT_POWERON];
    end
  end

  // brown-out status, ignored while detector off
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      brownout_status <= RST_BROWNOUT;
    end else if (brownout_event_i & brownout_detect_enable_i) begin
      brownout_status <= 1'b0;
    end else if (wr_reset_cause) begin
      brownout_status <= bus_req_i.wdata[BIT_BROWNOUT];
    end
  end

  // usart level edges for event status
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      receive_q  <= 1'b0;
      transmit_q <= 1'b1;
    end else begin
      receive_q  <= receive_full_i;
      transmit_q <= transmit_empty_i;
    end
  end

  always_comb begin
    status_set = set_one;
    status_set[BIT_EV_USART]   = (receive_full_i & ~receive_q)
                               | (transmit_empty_i & ~transmit_q);
    status_set[BIT_EV_CCP_TWO] = event_i.capture_compare_two
                               & ~ccp_mode_i.unit_two_pwm;
    status_set = status_set & (impl_mask | 8'h30);
  end

  // sticky event status, read clears, set wins
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= RST_FLAGS;
    end else if (rd_irq_status) begin
      irq_status <= status_set;
    end else begin
      irq_status <= irq_status | status_set;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= RST_IRQ_MASK;
    end else if (wr_irq_mask) begin
      irq_mask <= bus_req_i.wdata;
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  // peripheral request to the core
  assign periph_irq_o = peripheral_irq_enable_i
    & (|(flags_one_view & enables_one)
       | (capture_compare_two_flag
          & capture_compare_two_enable));

  // read mux, unused and unmapped read zero
  always_comb begin
    next_rd_data = 8'h00;
    if (bus_req_i.rd) begin
      case (bus_req_i.addr)
        OFS_FLAGS_ONE:   next_rd_data = flags_one_view & (impl_mask | 8'h30);
        OFS_FLAGS_TWO:   next_rd_data[BIT_CCP_TWO] = capture_compare_two_flag;
        OFS_ENABLES_ONE: next_rd_data = enables_one;
        OFS_ENABLES_TWO: begin
          next_rd_data[BIT_CCP_TWO] =
            capture_compare_two_enable;
        end
        OFS_RESET_CAUSE: begin
          next_rd_data[BIT_POWERON]  = poweron_status;
          next_rd_data[BIT_BROWNOUT] = brownout_status;
        end
        OFS_IRQ_STATUS:  next_rd_data = irq_status;
        OFS_IRQ_MASK:    next_rd_data = irq_mask;
        default:         next_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= next_rd_data;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_clear_write(int b);
    wr_flags_one && !bus_req_i.wdata[b];
  endsequence

  sequence s_ccp_two_armed;
    capture_compare_two_enable && !wr_enables_two
      && event_i.capture_compare_two && !ccp_mode_i.unit_two_pwm
    ##1 peripheral_irq_enable_i;
  endsequence

  property p_set_beats_clear;
    s_clear_write(BIT_SERIAL) ##0 event_i.serial_port
      |=> flags_one[BIT_SERIAL];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("serial flag lost to a clear");

  property p_parallel_hold;
    flags_one[BIT_PARALLEL] && !wr_flags_one
      |=> flags_one[BIT_PARALLEL];
  endproperty
  a_parallel_hold: assert property (p_parallel_hold)
    else $error("parallel port flag dropped");

  property p_conversion_set;
    event_i.conversion_done |=> flags_one[BIT_CONVERSION]
      == HAS_CONVERTER;
  endproperty
  a_conversion_set: assert property (p_conversion_set)
    else $error("conversion flag not set");

  property p_receive_read;
    bus_req_i.rd && bus_req_i.addr == OFS_FLAGS_ONE
      |=> rd_data_o[BIT_RECEIVE] == $past(receive_full_i);
  endproperty
  a_receive_read: assert property (p_receive_read)
    else $error("receive bit wrong");

  property p_transmit_read;
    bus_req_i.rd && bus_req_i.addr == OFS_FLAGS_ONE
      |=> rd_data_o[BIT_TRANSMIT] == $past(transmit_empty_i);
  endproperty
  a_transmit_read: assert property (p_transmit_read)
    else $error("transmit bit wrong");

  property p_pwm_ignored;
    event_i.capture_compare_one && ccp_mode_i.unit_one_pwm
      && !flags_one[BIT_CCP_ONE] && !wr_flags_one
      |=> !flags_one[BIT_CCP_ONE];
  endproperty
  a_pwm_ignored: assert property (p_pwm_ignored)
    else $error("pwm mode set unit one flag");

  property p_overflow_set;
    event_i.timer_overflow |=> flags_one[BIT_OVERFLOW] [*1]
      ##1 (flags_one[BIT_OVERFLOW] || $past(wr_flags_one));
  endproperty
  a_overflow_set: assert property (p_overflow_set)
    else $error("overflow flag not held");

  property p_reserved;
    !HAS_PARALLEL_PORT |-> !flags_one[BIT_PARALLEL];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved parallel bit set");

  property p_enables_two_read;
    bus_req_i.rd && bus_req_i.addr == OFS_ENABLES_TWO
      |=> rd_data_o[7:1] == 7'h00;
  endproperty
  a_enables_two_read: assert property (p_enables_two_read)
    else $error("enables two upper bits nonzero");

  property p_poweron_write;
    wr_reset_cause && bus_req_i.wdata[BIT_POWERON]
      ##1 !wr_reset_cause |-> poweron_status;
  endproperty
  a_poweron_write: assert property (p_poweron_write)
    else $error("power-on status not stored");

  property p_brownout_clear;
    brownout_event_i && brownout_detect_enable_i
      |=> !brownout_status;
  endproperty
  a_brownout_clear: assert property (p_brownout_clear)
    else $error("brown-out status not cleared");

  property p_ccp_two_request;
    s_ccp_two_armed |-> periph_irq_o;
  endproperty
  a_ccp_two_request: assert property (p_ccp_two_request)
    else $error("unit two request missing");

  property p_periph_gate;
    !peripheral_irq_enable_i |-> !periph_irq_o;
  endproperty
  a_periph_gate: assert property (p_periph_gate)
    else $error("request without peripheral enable");
endmodule

/* File: tb/pirq_periph_model.sv */
`timescale 1ns/1ps
module pirq_periph_model
  import pirq_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // commands from bench
  input  wire pirq_event_t fire_i,
  input  wire logic        rx_fill_i,
  input  wire logic        rx_take_i,
  input  wire logic        tx_load_i,
  input  wire logic        tx_send_i,
  // towards the block
  output pirq_event_t      event_o,
  output logic             receive_full_o,
  output logic             transmit_empty_o
);
  // one-cycle condition pulses
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      event_o <= '0;
    end else begin
      event_o <= fire_i;
    end
  end

  // usart buffer levels, holding-register access empties or fills
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      receive_full_o   <= 1'b0;
      transmit_empty_o <= 1'b1;
    end else begin
      if (rx_fill_i) receive_full_o <= 1'b1;
      else if (rx_take_i) receive_full_o <= 1'b0;
      if (tx_load_i) transmit_empty_o <= 1'b0;
      else if (tx_send_i) transmit_empty_o <= 1'b1;
    end
  end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import pirq_pkg::*;
  logic           sys_clk_i = 1'b0;
  logic           nrst_i    = 1'b0;
  pirq_bus_req_t  req       = '0;
  pirq_event_t    fire      = '0;
  pirq_event_t    ev;
  pirq_ccp_mode_t mode      = '0;
  logic           rx_fill   = 1'b0;
  logic           rx_take   = 1'b0;
  logic           tx_load   = 1'b0;
  logic           tx_send   = 1'b0;
  logic           bo_ev     = 1'b0;
  logic           bo_en     = 1'b1;
  logic           per_en    = 1'b0;
  logic           rx_full;
  logic           tx_empty;
  logic           pirq;
  logic           irq;
  logic [7:0]     rdat;
  logic [7:0]     rdat_lite;
  int             errors      = 0;
  int             checks_done = 0;
  int             cyc         = 0;

  always #50 sys_clk_i = ~sys_clk_i;

  pirq_periph_model i_model (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .fire_i(fire),
    .rx_fill_i(rx_fill), .rx_take_i(rx_take), .tx_load_i(tx_load),
    .tx_send_i(tx_send), .event_o(ev), .receive_full_o(rx_full),
    .transmit_empty_o(tx_empty)
  );

  pirq_flags i_dut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus_req_i(req),
    .rd_data_o(rdat), .event_i(ev), .ccp_mode_i(mode),
    .receive_full_i(rx_full), .transmit_empty_i(tx_empty),
    .brownout_event_i(bo_ev), .brownout_detect_enable_i(bo_en),
    .peripheral_irq_enable_i(per_en), .periph_irq_o(pirq), .irq_o(irq)
  );

  // variant without parallel port and converter
  pirq_flags #(
    .HAS_PARALLEL_PORT(1'b0), .HAS_CONVERTER(1'b0)
  ) i_dut_lite (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus_req_i(req),
    .rd_data_o(rdat_lite), .event_i(ev), .ccp_mode_i(mode),
    .receive_full_i(rx_full), .transmit_empty_i(tx_empty),
    .brownout_event_i(bo_ev), .brownout_detect_enable_i(bo_en),
    .peripheral_irq_enable_i(per_en), .periph_irq_o(), .irq_o()
  );

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req <= {a, d, 2'b10};
    @(posedge sys_clk_i);
    req <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    req <= {a, 8'h00, 2'b01};
    @(posedge sys_clk_i);
    req <= '0;
    #1;
    chk8($sformatf("reg %h", a), e, rdat);
  endtask

  task automatic pulse_ev(input pirq_event_t e);
    @(posedge sys_clk_i);
    fire <= e;
    @(posedge sys_clk_i);
    fire <= '0;
  endtask

  task automatic test_reset;
    logic [7:0] a [7] = '{8'h0d, 8'h8c, 8'h8d, 8'h8e, 8'h90, 8'h91, 8'h55};
    rd_chk(OFS_FLAGS_ONE, 8'h10);
    foreach (a[i]) rd_chk(a[i], 8'h00);
    $display("test reset done");
  endtask

  task automatic test_events;
    logic [7:0] pos [7] = '{8'h01, 8'h01, 8'h02, 8'h04, 8'h08, 8'h40, 8'h80};
    logic [7:0] a;
    logic [7:0] k;
    for (int i = 0; i < 7; i++) begin
      a = (i == 0) ? OFS_FLAGS_TWO : OFS_FLAGS_ONE;
      k = (i == 0) ? 8'h00 : 8'h10;
      pulse_ev(pirq_event_t'(7'(1 << i)));
      rd_chk(a, pos[i] | k);
      rd_chk(a, pos[i] | k);
      wr_reg(a, 8'h00);
      rd_chk(a, k);
    end
    mode <= 2'b11;
    pulse_ev(pirq_event_t'(7'h09));
    rd_chk(OFS_FLAGS_ONE, 8'h10);
    rd_chk(OFS_FLAGS_TWO, 8'h00);
    mode <= 2'b00;
    @(posedge sys_clk_i);
    fire <= pirq_event_t'(7'h10);
    @(posedge sys_clk_i);
    fire <= '0;
    req  <= {OFS_FLAGS_ONE, 8'h00, 2'b10};
    @(posedge sys_clk_i);
    req  <= '0;
    rd_chk(OFS_FLAGS_ONE, 8'h18);
    wr_reg(OFS_FLAGS_ONE, 8'h00);
    $display("test events done");
  endtask

  task automatic test_readonly;
    @(posedge sys_clk_i);
    rx_fill <= 1'b1;
    tx_load <= 1'b1;
    @(posedge sys_clk_i);
    rx_fill <= 1'b0;
    tx_load <= 1'b0;
    wr_reg(OFS_FLAGS_ONE, 8'hff);
    rd_chk(OFS_FLAGS_ONE, 8'hef);
    @(posedge sys_clk_i);
    rx_take <= 1'b1;
    tx_send <= 1'b1;
    @(posedge sys_clk_i);
    rx_take <= 1'b0;
    tx_send <= 1'b0;
    rd_chk(OFS_FLAGS_ONE, 8'hdf);
    wr_reg(OFS_FLAGS_ONE, 8'h00);
    wr_reg(OFS_ENABLES_TWO, 8'hff);
    rd_chk(OFS_ENABLES_TWO, 8'h01);
    wr_reg(OFS_FLAGS_TWO, 8'hff);
    rd_chk(OFS_FLAGS_TWO, 8'h01);
    wr_reg(OFS_FLAGS_TWO, 8'h00);
    wr_reg(OFS_ENABLES_TWO, 8'h00);
    $display("test read-only done");
  endtask

  task automatic test_power;
    wr_reg(OFS_RESET_CAUSE, 8'hff);
    rd_chk(OFS_RESET_CAUSE, 8'h03);
    bo_en <= 1'b0;
    @(posedge sys_clk_i);
    bo_ev <= 1'b1;
    @(posedge sys_clk_i);
    bo_ev <= 1'b0;
    rd_chk(OFS_RESET_CAUSE, 8'h03);
    bo_en <= 1'b1;
    @(posedge sys_clk_i);
    bo_ev <= 1'b1;
    @(posedge sys_clk_i);
    bo_ev <= 1'b0;
    rd_chk(OFS_RESET_CAUSE, 8'h02);
    $display("test power done");
  endtask

  task automatic test_irq;
    wr_reg(OFS_FLAGS_ONE, 8'h00);
    rd_chk(OFS_IRQ_STATUS, 8'hff);
    wr_reg(OFS_ENABLES_ONE, 8'h01);
    per_en <= 1'b1;
    pulse_ev(pirq_event_t'(7'h02));
    @(posedge sys_clk_i);
    #1;
    chk1("periph irq", 1'b1, pirq);
    chk1("irq masked", 1'b0, irq);
    per_en <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk1("periph irq off", 1'b0, pirq);
    wr_reg(OFS_IRQ_MASK, 8'h01);
    #1;
    chk1("irq", 1'b1, irq);
    rd_chk(OFS_IRQ_STATUS, 8'h01);
    chk1("irq cleared", 1'b0, irq);
    wr_reg(OFS_ENABLES_ONE, 8'h00);
    wr_reg(OFS_FLAGS_TWO, 8'h00);
    wr_reg(OFS_ENABLES_TWO, 8'h01);
    per_en <= 1'b1;
    pulse_ev(pirq_event_t'(7'h01));
    #1;
    chk1("unit two idle", 1'b0, pirq);
    @(posedge sys_clk_i);
    #1;
    chk1("unit two irq", 1'b1, pirq);
    per_en <= 1'b0;
    $display("test irq done");
  endtask

  task automatic test_variant;
    pulse_ev(pirq_event_t'(7'h60));
    rd_chk(OFS_FLAGS_ONE, 8'hd0);
    chk8("lite flags one", 8'h10, rdat_lite);
    wr_reg(OFS_FLAGS_ONE, 8'h00);
    $display("test variant done");
  endtask

  task automatic test_rereset;
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    rd_chk(OFS_RESET_CAUSE, 8'h00);
    rd_chk(OFS_FLAGS_ONE, 8'h10);
    $display("test rereset done");
  endtask

  initial begin
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    test_reset();
    test_events();
    test_readonly();
    test_variant();
    test_power();
    test_irq();
    test_rereset();
    report_and_stop();
  end
endmodule
